/* hw/gtu_top.sv */
`timescale 1ns/1ps
module gtu_top
	import gtu_pkg::*;
(
	// clock and reset
	input  wire logic             REF_CLK_I,
	input  wire logic             RST_B_I,
	// external pins: index 0 aux a, 1 core, 2 aux b, 3 group-two aux, 4 group-two core
	input  wire logic [4:0]       TIMER_COUNT_INPUT_I,
	input  wire logic [4:0]       TIMER_DIRECTION_INPUT_I,
	input  wire logic             CAPTURE_PIN_INPUT_I,
	// per-timer configuration
	input  wire logic [4:0]       RUN_I,
	input  wire logic [4:0]       DOWN_I,
	input  wire logic [4:0]       EXT_DIR_EN_I,
	input  wire logic [14:0]      PRESCALE_I,
	input  wire logic [9:0]       EDGE_SEL_I,
	input  wire logic [4:0]       GATE_LEVEL_I,
	input  wire gtu_pkg::gtu_mode_t MODE_A_I,
	input  wire gtu_pkg::gtu_mode_t MODE_CORE_I,
	input  wire gtu_pkg::gtu_mode_t MODE_B_I,
	input  wire gtu_pkg::gtu_aux_t  AUX_A_FUNC_I,
	input  wire gtu_pkg::gtu_aux_t  AUX_B_FUNC_I,
	input  wire logic [1:0]       RELOAD_LATCH_SEL_A_I,
	input  wire logic [1:0]       RELOAD_LATCH_SEL_B_I,
	input  wire logic [1:0]       G2_EXT_COUNT_I,
	input  wire logic             G2_AUX_CHAIN_I,
	input  wire logic             G2_CORE_RELOAD_EN_I,
	input  wire logic [1:0]       CAPTURE_EDGE_SEL_I,
	input  wire logic [1:0]       CAPTURE_SRC_I,
	input  wire logic             CAPTURE_CLEAR_EN_I,
	// state and pins
	output logic [15:0]           FIRST_AUX_TIMER_A_O,
	output logic [15:0]           FIRST_CORE_TIMER_O,
	output logic [15:0]           FIRST_AUX_TIMER_B_O,
	output logic [15:0]           SECOND_AUX_TIMER_O,
	output logic [15:0]           SECOND_CORE_TIMER_O,
	output logic [15:0]           CAPTURE_RELOAD_REGISTER_O,
	output logic                  FIRST_TOGGLE_OUTPUT_O,
	output logic                  SECOND_TOGGLE_OUTPUT_O,
	output logic                  SECOND_CORE_WRAP_O
);
	import gtu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic [4:0] cnt_meta_reg;
	logic [4:0] cnt_sync_reg;
	logic [4:0] cnt_old_reg;
	logic [4:0] dir_meta_reg;
	logic [4:0] dir_sync_reg;
	logic [4:0] dir_old_reg;
	logic       cap_meta_reg;
	logic       cap_sync_reg;
	logic       cap_old_reg;

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
		begin
			cnt_meta_reg <= 5'h00;
			cnt_sync_reg <= 5'h00;
			cnt_old_reg  <= 5'h00;
			dir_meta_reg <= 5'h00;
			dir_sync_reg <= 5'h00;
			dir_old_reg  <= 5'h00;
			cap_meta_reg <= 1'b0;
			cap_sync_reg <= 1'b0;
			cap_old_reg  <= 1'b0;
		end
		else
		begin
			cnt_meta_reg <= TIMER_COUNT_INPUT_I;
			cnt_sync_reg <= cnt_meta_reg;
			cnt_old_reg  <= cnt_sync_reg;
			dir_meta_reg <= TIMER_DIRECTION_INPUT_I;
			dir_sync_reg <= dir_meta_reg;
			dir_old_reg  <= dir_sync_reg;
			cap_meta_reg <= CAPTURE_PIN_INPUT_I;
			cap_sync_reg <= cap_meta_reg;
			cap_old_reg  <= cap_sync_reg;
		end
	end

	function automatic logic edge_hit(input logic now_v, input logic old_v,
		input logic [1:0] sel);
		edge_hit = (sel[0] && now_v && !old_v) || (sel[1] && !now_v && old_v);
	endfunction

	logic [4:0] cnt_edge;
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			cnt_edge[i] = edge_hit(cnt_sync_reg[i], cnt_old_reg[i], EDGE_SEL_I[2*i +: 2]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// base clocks: group one every 4 cycles, group two every 2
	logic [1:0] g1_base_reg;
	logic       g2_base_reg;
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
		begin
			g1_base_reg <= 2'h0;
			g2_base_reg <= 1'b0;
		end
		else
		begin
			g1_base_reg <= g1_base_reg + 2'h1;
			g2_base_reg <= ~g2_base_reg;
		end
	end
	wire g1_tick = (g1_base_reg == 2'(GTU_G1_BASE - 1));
	wire g2_tick = g2_base_reg;

	// free running prescaler per group, shared by that group's timers; a tap of 2^n base ticks per timer
	logic [7:0] pre_g1_reg;
	logic [7:0] pre_g2_reg;
	logic [7:0] pre_g1_next;
	logic [7:0] pre_g2_next;
	assign pre_g1_next = pre_g1_reg + 8'h01;
	assign pre_g2_next = pre_g2_reg + 8'h01;
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
		begin
			pre_g1_reg <= 8'h00;
			pre_g2_reg <= 8'h00;
		end
		else
		begin
			if (g1_tick)
				pre_g1_reg <= pre_g1_next;
			if (g2_tick)
				pre_g2_reg <= pre_g2_next;
		end
	end

	// true when the prescaler carries into bit n on this base tick
	function automatic logic pre_fire(input logic [7:0] cnt, input logic [2:0] n);
		logic [7:0] mask;
		mask = (8'h01 << n) - 8'h01;
		pre_fire = ((cnt & mask) == mask);
	endfunction

	logic [4:0] pre_en;
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			pre_en[i] = g1_tick && pre_fire(pre_g1_reg, PRESCALE_I[3*i +: 3]);
		for (int i = 3; i < 5; i++)
			pre_en[i] = g2_tick && pre_fire(pre_g2_reg, PRESCALE_I[3*i +: 3]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// incremental encoder decode for the group-one timers
	function automatic logic [1:0] quad(input logic a, input logic b,
		input logic a_old, input logic b_old);
		logic moved;
		moved = (a ^ a_old) ^ (b ^ b_old);
		// returns {step, down}; illegal double changes are dropped
		quad = {moved, (a ^ a_old) ? (a == b) : (a != b)};
	endfunction

	logic [15:0] cnt_val [5];
	logic [4:0]  wrap;
	logic [4:0]  step;
	logic [4:0]  down;
	logic [4:0]  load;
	logic [15:0] load_val [5];
	logic        tl1_reg;
	logic        tl2_reg;
	logic        tl1_old_reg;
	logic [15:0] capture_reload_register_reg;
	gtu_mode_t   mode [3];
	assign mode[0] = MODE_A_I;
	assign mode[1] = MODE_CORE_I;
	assign mode[2] = MODE_B_I;

	wire aux_a_stop = AUX_A_FUNC_I inside {GTU_AUX_CAPTURE, GTU_AUX_RELOAD};
	wire aux_b_stop = AUX_B_FUNC_I inside {GTU_AUX_CAPTURE, GTU_AUX_RELOAD};
	wire tl1_rise = tl1_reg && !tl1_old_reg;
	wire tl1_fall = !tl1_reg && tl1_old_reg;

	////////////////////////////////////////////////////////////////////////////////
	// count step and direction per timer
	always_comb
	begin
		logic [1:0] q;
		q = 2'h0;
		for (int i = 0; i < 3; i++)
		begin
			q = quad(cnt_sync_reg[i], dir_sync_reg[i], cnt_old_reg[i], dir_old_reg[i]);
			down[i] = EXT_DIR_EN_I[i] ? (dir_sync_reg[i] ^ DOWN_I[i]) : DOWN_I[i];
			case (mode[i])
				GTU_MODE_TIMER:   step[i] = pre_en[i];
				GTU_MODE_GATED:   step[i] = pre_en[i] &&
					(cnt_sync_reg[i] == GATE_LEVEL_I[i]);
				GTU_MODE_COUNTER: step[i] = cnt_edge[i];
				GTU_MODE_INCR:
				begin
					step[i] = q[1];
					down[i] = q[0] ^ DOWN_I[i];
				end
				default:          step[i] = 1'b0;
			endcase
			step[i] = step[i] && RUN_I[i];
		end
		// auxiliary chaining on core toggle latch; stopped in capture/reload role
		if (AUX_A_FUNC_I == GTU_AUX_CHAIN)
			step[0] = RUN_I[0] && edge_hit(tl1_reg, tl1_old_reg, EDGE_SEL_I[1:0]);
		if (AUX_B_FUNC_I == GTU_AUX_CHAIN)
			step[2] = RUN_I[2] && edge_hit(tl1_reg, tl1_old_reg, EDGE_SEL_I[5:4]);
		if (aux_a_stop)
			step[0] = 1'b0;
		if (aux_b_stop)
			step[2] = 1'b0;
		// group two: prescaled or external events, aux may chain on core latch
		for (int i = 3; i < 5; i++)
		begin
			down[i] = EXT_DIR_EN_I[i] ? dir_sync_reg[i] : DOWN_I[i];
			step[i] = RUN_I[i] && (G2_EXT_COUNT_I[i-3] ? cnt_edge[i] : pre_en[i]);
		end
		if (G2_AUX_CHAIN_I)
			step[3] = RUN_I[3] && (tl2_reg != SECOND_TOGGLE_OUTPUT_O);
	end

	////////////////////////////////////////////////////////////////////////////////
	// loads: captures into aux timers a and b, clear of the group-two aux, reloads of the cores
	wire cap_a  = (AUX_A_FUNC_I == GTU_AUX_CAPTURE) && cnt_edge[0];
	wire cap_b  = (AUX_B_FUNC_I == GTU_AUX_CAPTURE) && cnt_edge[2];
	wire rel_a  = (AUX_A_FUNC_I == GTU_AUX_RELOAD) &&
		(cnt_edge[0] || (RELOAD_LATCH_SEL_A_I[0] && tl1_rise) ||
		(RELOAD_LATCH_SEL_A_I[1] && tl1_fall));
	wire rel_b  = (AUX_B_FUNC_I == GTU_AUX_RELOAD) &&
		(cnt_edge[2] || (RELOAD_LATCH_SEL_B_I[0] && tl1_rise) ||
		(RELOAD_LATCH_SEL_B_I[1] && tl1_fall));
	wire g2_cap = (CAPTURE_SRC_I == 2'h0) ?
		edge_hit(cap_sync_reg, cap_old_reg, CAPTURE_EDGE_SEL_I) :
		((CAPTURE_SRC_I[0] && (cnt_sync_reg[1] ^ cnt_old_reg[1])) ||
		(CAPTURE_SRC_I[1] && (dir_sync_reg[1] ^ dir_old_reg[1])));

	always_comb
	begin
		load = 5'h00;
		load[0] = cap_a;
		load[2] = cap_b;
		load[1] = rel_a || rel_b;
		load[3] = g2_cap && CAPTURE_CLEAR_EN_I;
		load[4] = G2_CORE_RELOAD_EN_I && wrap[4];
		load_val[0] = cnt_val[1];
		load_val[2] = cnt_val[1];
		// a simultaneous reload from both aux timers favours aux a
		load_val[1] = rel_a ? cnt_val[0] : cnt_val[2];
		load_val[3] = GTU_RESET_VAL;
		load_val[4] = capture_reload_register_reg;
	end

	// five identical counters, one per timer
	for (genvar g = 0; g < 5; g++)
	begin : g_tmr                                                                   
		gtu_counter #(.WIDTH(GTU_WIDTH)) u_cnt (
			.clk_i      (REF_CLK_I),
			.rst_b_i    (RST_B_I),
			.step_i     (step[g]),
			.down_i     (down[g]),
			.load_i     (load[g]),
			.load_val_i (load_val[g]),
			.count_o    (cnt_val[g]),
			.wrap_o     (wrap[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// toggle latches and capture register
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
		begin
			tl1_reg     <= 1'b0;
			tl1_old_reg <= 1'b0;
		end
		else
		begin
			tl1_old_reg <= tl1_reg;
			if (wrap[1])
				tl1_reg <= ~tl1_reg;
		end
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
			tl2_reg <= 1'b0;
		else if (wrap[4])
			tl2_reg <= ~tl2_reg;
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
			capture_reload_register_reg <= GTU_RESET_VAL;
		else if (g2_cap)
			capture_reload_register_reg <= cnt_val[3];
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_B_I)
		begin
			FIRST_AUX_TIMER_A_O       <= GTU_RESET_VAL;
			FIRST_CORE_TIMER_O        <= GTU_RESET_VAL;
			FIRST_AUX_TIMER_B_O       <= GTU_RESET_VAL;
			SECOND_AUX_TIMER_O        <= GTU_RESET_VAL;
			SECOND_CORE_TIMER_O       <= GTU_RESET_VAL;
			CAPTURE_RELOAD_REGISTER_O <= GTU_RESET_VAL;
			FIRST_TOGGLE_OUTPUT_O     <= 1'b0;
			SECOND_TOGGLE_OUTPUT_O    <= 1'b0;
			SECOND_CORE_WRAP_O        <= 1'b0;
		end
		else
		begin
			FIRST_AUX_TIMER_A_O       <= cnt_val[0];
			FIRST_CORE_TIMER_O        <= cnt_val[1];
			FIRST_AUX_TIMER_B_O       <= cnt_val[2];
			SECOND_AUX_TIMER_O        <= cnt_val[3];
			SECOND_CORE_TIMER_O       <= cnt_val[4];
			CAPTURE_RELOAD_REGISTER_O <= capture_reload_register_reg;
			FIRST_TOGGLE_OUTPUT_O     <= tl1_reg;
			SECOND_TOGGLE_OUTPUT_O    <= tl2_reg;
			SECOND_CORE_WRAP_O        <= wrap[4];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	g1_base_rate_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		g1_tick |=> !g1_tick [*3] ##1 g1_tick)
		else $error("group one base tick not every four cycles");
	g2_base_rate_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		g2_tick |=> !g2_tick ##1 g2_tick)
		else $error("group two base tick not every two cycles");
	aux_stopped_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		aux_a_stop && !load[0] |=> $stable(cnt_val[0]))
		else $error("aux timer a moved while in capture or reload role");
	tl1_flip_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		wrap[1] |=> tl1_reg != $past(tl1_reg))
		else $error("core toggle latch missed a wrap");
	tl2_pin_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		wrap[4] |=> ##1 SECOND_TOGGLE_OUTPUT_O == tl2_reg)
		else $error("second toggle output not following latch");
	capture_take_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		g2_cap |=> capture_reload_register_reg == $past(cnt_val[3]))
		else $error("capture register missed group two aux value");
	capture_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		g2_cap && CAPTURE_CLEAR_EN_I |=> cnt_val[3] == 16'h0000)
		else $error("group two aux not cleared after capture");
	core_capture_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		cap_a |=> cnt_val[0] == $past(cnt_val[1]))
		else $error("aux a did not capture the core value");
	core_reload_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		rel_b && !rel_a |=> cnt_val[1] == $past(cnt_val[2]))
		else $error("core not reloaded from aux b");
	g2_reload_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		G2_CORE_RELOAD_EN_I && wrap[4] |=> cnt_val[4] == $past(capture_reload_register_reg))
		else $error("group two core not reloaded on wrap");
endmodule

/* hw/gtu_pkg.sv */
package gtu_pkg;
	// timer modes of the first group
	typedef enum logic [1:0] {
		GTU_MODE_TIMER   = 2'h0,
		GTU_MODE_GATED   = 2'h1,
		GTU_MODE_COUNTER = 2'h2,
		GTU_MODE_INCR    = 2'h3
	} gtu_mode_t;

	// auxiliary timer function in the first group
	typedef enum logic [1:0] {
		GTU_AUX_COUNT   = 2'h0,
		GTU_AUX_CHAIN   = 2'h1,
		GTU_AUX_CAPTURE = 2'h2,
		GTU_AUX_RELOAD  = 2'h3
	} gtu_aux_t;

	// edge select codes: bit0 rising, bit1 falling
	localparam logic [1:0] GTU_EDGE_RISE = 2'h1;
	localparam logic [1:0] GTU_EDGE_FALL = 2'h2;

	localparam int         GTU_WIDTH      = 16;
	localparam int         GTU_PRE_BITS   = 3;
	localparam int         GTU_G1_BASE    = 4;
	localparam int         GTU_G2_BASE    = 2;
	localparam logic [15:0] GTU_RESET_VAL = 16'h0000;
endpackage

/* hw/gtu_counter.sv */
`timescale 1ns/1ps
// one 16-bit up/down counter with load and wrap detection
module gtu_counter
	import gtu_pkg::*;
#(
	parameter int WIDTH = GTU_WIDTH
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// control
	input  wire logic             step_i,
	input  wire logic             down_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] load_val_i,
	// state
	output logic      [WIDTH-1:0] count_o,
	output logic                  wrap_o
);
	logic [WIDTH-1:0] count_next;

	always_comb
	begin
		count_next = down_i ? count_o - 1'b1 : count_o + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			count_o <= '0;
		else if (load_i)
			count_o <= load_val_i;
		else if (step_i)
			count_o <= count_next;
	end

	// wrap pulse: all ones to zero going up, zero to all ones going down
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			wrap_o <= 1'b0;
		else
			wrap_o <= step_i && !load_i &&
				(down_i ? (count_o == '0) : (count_o == {WIDTH{1'b1}}));
	end
endmodule

/* verification/gtu_pin_model.sv */
`timescale 1ns/1ps
module gtu_pin_model
(
	// clock
	input  wire logic       clk_i,
	// pins into the timer block
	output logic      [4:0] count_o,
	output logic      [4:0] dir_o,
	output logic            cap_o
);
	logic [1:0] quad_phase;
	////////////////////////////////////////
	// pins move just after an edge and hold well past the two-flop sync
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic clear();
		count_o = 5'h00;
		dir_o = 5'h00;
		cap_o = 1'b0;
		quad_phase = 2'h0;
	endtask
	task automatic set_count(input int i, input logic v);
		hold(1);
		count_o[i] = v;
	endtask
	task automatic set_dir(input int i, input logic v);
		hold(1);
		dir_o[i] = v;
	endtask
	task automatic pulse(input int i);
		set_count(i, 1'b1);
		hold(6);
		count_o[i] = 1'b0;
		hold(6);
	endtask
	// gray order: one track moves per step, as a real encoder does
	task automatic quad(input logic fwd, input int n);
		repeat (n)
		begin
			quad_phase = fwd ? quad_phase + 2'h1 : quad_phase - 2'h1;
			count_o[1] = quad_phase[0] ^ quad_phase[1];
			dir_o[1] = quad_phase[1];
			hold(8);
		end
	endtask
	task automatic cap_pulse();
		hold(1);
		cap_o = 1'b1;
		hold(6);
		cap_o = 1'b0;
		hold(6);
	endtask
endmodule

/* verification/test_dual_group_general_timer.sv */
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		n_compared++; \
		if ((a) !== (b)) \
		begin \
			n_errors++; \
			$display("unexpected at %0t: got %0h, expected %0h", $time, (a), (b)); \
		end \
	end
module test_dual_group_general_timer;
	import gtu_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b;
	logic [4:0]  pc, pd, run, dn, xd, gl;
	logic        pcap, o1, o2, w6, g2c, g2r, cclr;
	logic [14:0] pre;
	logic [9:0]  es;
	logic [1:0]  rsa, rsb, g2x, ces, csrc;
	gtu_mode_t   ma, mc, mb;
	gtu_aux_t    fa, fb;
	logic [15:0] ta, tc, tb4, t5, t6, cr;
	logic [31:0] seed = 32'h0000c10c;
	int          n_errors = 0;
	int          n_compared = 0;

	always #12.5 clk = ~clk;

	gtu_pin_model gtu_pin_model_inst (.clk_i(clk), .count_o(pc), .dir_o(pd), .cap_o(pcap));
	gtu_top gtu_top_inst (
		.REF_CLK_I(clk), .RST_B_I(rst_b), .TIMER_COUNT_INPUT_I(pc),
		.TIMER_DIRECTION_INPUT_I(pd), .CAPTURE_PIN_INPUT_I(pcap), .RUN_I(run),
		.DOWN_I(dn), .EXT_DIR_EN_I(xd), .PRESCALE_I(pre), .EDGE_SEL_I(es),
		.GATE_LEVEL_I(gl), .MODE_A_I(ma), .MODE_CORE_I(mc), .MODE_B_I(mb),
		.AUX_A_FUNC_I(fa), .AUX_B_FUNC_I(fb), .RELOAD_LATCH_SEL_A_I(rsa),
		.RELOAD_LATCH_SEL_B_I(rsb), .G2_EXT_COUNT_I(g2x), .G2_AUX_CHAIN_I(g2c),
		.G2_CORE_RELOAD_EN_I(g2r), .CAPTURE_EDGE_SEL_I(ces), .CAPTURE_SRC_I(csrc),
		.CAPTURE_CLEAR_EN_I(cclr), .FIRST_AUX_TIMER_A_O(ta), .FIRST_CORE_TIMER_O(tc),
		.FIRST_AUX_TIMER_B_O(tb4), .SECOND_AUX_TIMER_O(t5), .SECOND_CORE_TIMER_O(t6),
		.CAPTURE_RELOAD_REGISTER_O(cr), .FIRST_TOGGLE_OUTPUT_O(o1),
		.SECOND_TOGGLE_OUTPUT_O(o2), .SECOND_CORE_WRAP_O(w6)
	);
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	function automatic int rnd(input int m);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed % m);
	endfunction
	function automatic logic [15:0] tv(input int i);
		case (i)
			0: return ta;
			1: return tc;
			2: return tb4;
			3: return t5;
			default: return t6;
		endcase
	endfunction
	// steps expected over a 256-cycle window at the chosen prescale
	function automatic logic [15:0] steps(input int i);
		int s;
		s = 256 / ((i < 3 ? GTU_G1_BASE : GTU_G2_BASE) << pre[3*i +: 3]);
		return dn[i] ? 16'(-s) : 16'(s);
	endfunction
	function automatic logic near(input int a, input int b);
		return (a >= b - 8) && (a <= b + 8);
	endfunction
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail_wait();
		n_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		print_verdict();
	endtask
	task automatic rst();
		rst_b = 1'b0;
		{run, dn, xd, gl, pre, es, rsa, rsb, g2x, ces, csrc, g2c, g2r, cclr} = '0;
		ma = GTU_MODE_TIMER;
		mc = GTU_MODE_TIMER;
		mb = GTU_MODE_TIMER;
		fa = GTU_AUX_COUNT;
		fb = GTU_AUX_COUNT;
		gtu_pin_model_inst.clear();
		tick(3);
		`CHK({ta, tc, tb4, t5, t6, cr, o1, o2, w6}, 99'h0)
		rst_b = 1'b1;
		tick(1);
	endtask
	task automatic span(input int i, input int w, input logic [15:0] e);
		logic [15:0] v0;
		v0 = tv(i);
		tick(w);
		`CHK(16'(tv(i) - v0), e)
	endtask
	task automatic wait_wrap();
		for (int k = 0; k < 600 && w6 !== 1'b1; k++) tick(1);
		if (w6 !== 1'b1) fail_wait();
	endtask
	task automatic phase1(output int len);
		logic s;
		s = o1;
		len = 0;
		while (o1 === s && len < 3000)
		begin
			tick(1);
			len++;
		end
		if (len >= 3000) fail_wait();
	endtask
	////////////////////////////////////////
	initial
	begin
		int k1, k2, h, l, v, n;
		rst();
		for (int i = 0; i < 5; i++)
		begin
			pre[3*i +: 3] = 3'(rnd(3));
			dn[i] = 1'(rnd(2));
		end
		// hand-picked finest rates for one timer of each group
		pre[2:0] = 3'h0;
		pre[11:9] = 3'h0;
		run = 5'h1f;
		tick(8);
		for (int i = 0; i < 5; i++) span(i, 256, steps(i));
		$display("test prescaled count finished");
		rst();
		mc = GTU_MODE_GATED;
		gl[1] = 1'b1;
		run[1] = 1'b1;
		tick(8);
		span(1, 64, 16'h0000);
		gtu_pin_model_inst.set_count(1, 1'b1);
		tick(8);
		span(1, 64, 16'(64 / GTU_G1_BASE));
		$display("test gated finished");
		rst();
		mc = GTU_MODE_COUNTER;
		es = 10'h015;
		fa = GTU_AUX_CAPTURE;
		fb = GTU_AUX_CAPTURE;
		run = 5'h07;
		k1 = 3 + rnd(8);
		k2 = 3 + rnd(8);
		repeat (k1) gtu_pin_model_inst.pulse(1);
		tick(8);
		`CHK(tc, 16'(k1))
		gtu_pin_model_inst.pulse(0);
		repeat (k2) gtu_pin_model_inst.pulse(1);
		gtu_pin_model_inst.pulse(2);
		tick(8);
		`CHK({ta, tb4}, {16'(k1), 16'(k1 + k2)})
		// aux a sets the high time, aux b the low time
		fa = GTU_AUX_RELOAD;
		fb = GTU_AUX_RELOAD;
		rsa = 2'h1;
		rsb = 2'h2;
		mc = GTU_MODE_TIMER;
		dn[1] = 1'b1;
		repeat (3)
		begin
			v = o1;
			phase1(n);
			if (v == 1) h = n;
			else l = n;
		end
		`CHK({near(h, 4 * (k1 + 1)), near(l, 4 * (k1 + k2 + 1))}, 2'h3)
		$display("test capture and reload finished");
		rst();
		mc = GTU_MODE_INCR;
		es[3:2] = 2'h3;
		run[1] = 1'b1;
		tick(4);
		n = 4 + rnd(6);
		v = tc;
		gtu_pin_model_inst.quad(1'b1, n);
		tick(6);
		`CHK(tc, 16'(v + n))
		gtu_pin_model_inst.quad(1'b0, n);
		tick(6);
		`CHK(tc, 16'(v))
		$display("test encoder finished");
		rst();
		// core underflows on its first step; aux a takes both latch edges, aux b falls only
		fa = GTU_AUX_CHAIN;
		fb = GTU_AUX_CHAIN;
		es = 10'h023;
		run = 5'h07;
		dn[1] = 1'b1;
		tick(16);
		`CHK({ta, tb4, o1}, {16'h0001, 16'h0000, 1'b1})
		$display("test chaining finished");
		rst();
		run[4] = 1'b1;
		xd[4] = 1'b1;
		gtu_pin_model_inst.set_dir(4, 1'b1);
		tick(8);
		span(4, 64, 16'hffe0);
		gtu_pin_model_inst.set_dir(4, 1'b0);
		tick(8);
		span(4, 64, 16'h0020);
		rst();
		dn[4] = 1'b1;
		run[4] = 1'b1;
		wait_wrap();
		`CHK(t6, 16'hffff)
		tick(1);
		`CHK({o2, w6}, 2'h2)
		rst();
		g2x[1] = 1'b1;
		es[9:8] = GTU_EDGE_FALL;
		run[4] = 1'b1;
		repeat (3) gtu_pin_model_inst.pulse(4);
		tick(8);
		`CHK(t6, 16'h0003)
		rst();
		run[3] = 1'b1;
		tick(20 + rnd(20));
		run[3] = 1'b0;
		tick(4);
		v = t5;
		cclr = 1'b1;
		ces = GTU_EDGE_RISE;
		gtu_pin_model_inst.cap_pulse();
		tick(6);
		`CHK({cr, t5}, {16'(v), 16'h0000})
		run[3] = 1'b1;
		tick(10 + rnd(10));
		run[3] = 1'b0;
		cclr = 1'b0;
		csrc = 2'h1;
		tick(4);
		v = t5;
		gtu_pin_model_inst.set_count(1, 1'b1);
		tick(6);
		`CHK(cr, 16'(v))
		g2c = 1'b1;
		// counting down wraps at once and then after the reload, not after 2^16 steps
		dn[4] = 1'b1;
		g2r = 1'b1;
		run[3] = 1'b1;
		tick(2);
		n = t5;
		run[4] = 1'b1;
		wait_wrap();
		tick(1);
		wait_wrap();
		tick(3);
		`CHK(t5, 16'(n + 2))
		`CHK(16'(16'(v) - t6) <= 16'h0002, 1'b1)
		$display("test second group finished");
		print_verdict();
	end
endmodule
